//--- common/isr_cfg.svh
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH
// Behaviour
// - Start/stop irq enables add flag events only in modes lacking them.
// - Ninth clock carries acknowledge; receiver pulls data low to accept.
// - Data level at the ninth rising clock lands in ack received status.
// - With hold enables, stretch before acknowledge; drive ack data value.
// - Buffer full or overflow set means not-acknowledge; overwrite alters.
// - Ack time status sets after eighth falling edge when addressed.
// - Ack time status works only with address or data hold enabled.
// - Four modes: 7/10-bit addressing, with or without start/stop irq.
// - Start/stop irq modes flag every start, restart and stop.
// - First byte after start compared to address; mismatch idles quietly.
// - Address mask qualifies every address compare.
// - 7-bit addressing ignores the read/write bit of the address byte.
// - 10-bit high byte matches 11110, address bits 2:1, then read/write.
// - After high byte ack, set update flag, hold clock for new address.
// - Low byte compared on eight bits; flag, update flag and hold anyway.
// - Writing the slave address clears the update-address flag.
// - 10-bit read needs prior full write match, then restart and high.
// - Matching write address clears read/write, buffers and acknowledges.
// - Interrupt flag sets per transferred byte until software clears it.
// - With clock stretch enable, hold clock after each acknowledged byte.
// - Reading the receive buffer clears the buffer-full flag.
// - Start sets start status; stop sets stop status and idles.
// - Start is data falling with clock high; stop is data rising.
// - Data changes while clock low, sampled on rising clock.
// - Restart resets the slave logic just like a start.

`define ISR_MODE_7BIT     4'h6
`define ISR_MODE_10BIT    4'h7
`define ISR_MODE_7BIT_SP  4'hE
`define ISR_MODE_10BIT_SP 4'hF
`define ISR_BITS_PER_BYTE 4'h8
`define ISR_TEN_HI_PREFIX 5'h1E
`define ISR_ADDR_RESET    8'h00
`define ISR_BUF_RESET     8'h00
`define ISR_ADDR_HI_MSB   2
`define ISR_ADDR_HI_LSB   1
`define ISR_SYNC_WIDTH    2
`define ISR_SYNC_SCL      0
`define ISR_SYNC_SDA      1
`endif

//--- common/isr_pkg.sv
`include "isr_cfg.svh"
package isr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_ACK,
    ST_READ
  } isr_state_t;

  typedef struct packed {
    logic [3:0] port_mode_select;
    logic       start_irq_enable;
    logic       stop_irq_enable;
    logic       address_hold_enable;
    logic       data_hold_enable;
    logic       buffer_overwrite_enable;
    logic       clock_stretch_enable;
    logic       ack_data_value;
    logic [7:0] address_mask;
  } isr_ctrl_t;

  typedef struct packed {
    logic [7:0] receive_buffer;
    logic [7:0] slave_address_reg;
    logic       buffer_full_flag;
    logic       receive_overflow_flag;
    logic       port_interrupt_flag;
    logic       ack_time_status;
    logic       ack_received_status;
    logic       update_address_flag;
    logic       start_status;
    logic       stop_status;
    logic       read_write_status;
    logic       data_address_status;
    logic       clock_release_bit;
  } isr_status_t;

endpackage

//--- design/isr_slave.sv
`timescale 1ns/10ps
`include "isr_cfg.svh"
module isr_slave
(
  input  wire logic                 MCLK,
  input  wire logic                 RST_N,
  input  wire logic                 SCL_I,
  output logic                      SCL_O,
  output logic                      SCL_OE,
  input  wire logic                 SDA_I,
  output logic                      SDA_O,
  output logic                      SDA_OE,
  input  wire isr_pkg::isr_ctrl_t   CTRL,
  input  wire logic [7:0]           SLAVE_ADDR_WDATA,
  input  wire logic                 SLAVE_ADDR_WE,
  input  wire logic                 CLOCK_RELEASE_SET,
  input  wire logic                 IRQ_FLAG_CLR,
  input  wire logic                 BUF_READ,
  input  wire logic                 OVERFLOW_CLR,
  output isr_pkg::isr_status_t      STATUS
);

  logic               rst_meta_q;
  logic               rst_n_q;
  logic [1:0]         line_lvl;
  logic [1:0]         line_rise;
  logic [1:0]         line_fall;
  logic               scl_lvl;
  logic               sda_lvl;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_det;
  logic               stop_det;

  isr_pkg::isr_state_t state_q, state_d;
  logic [3:0]         cnt_q, cnt_d;
  logic [7:0]         shift_q, shift_d;
  logic [7:0]         buf_q, buf_d;
  logic [7:0]         addr_q, addr_d;
  logic               bf_q, bf_d;
  logic               ov_q, ov_d;
  logic               if_q, if_d;
  logic               ackt_q, ackt_d;
  logic               ack_received_status_q, ack_received_status_d;
  logic               ua_q, ua_d;
  logic               ua_hold_q, ua_hold_d;
  logic               start_q, start_d;
  logic               stop_q, stop_d;
  logic               rw_q, rw_d;
  logic               da_q, da_d;
  logic               ckp_q, ckp_d;
  logic               fully_q, fully_d;
  logic               lo_phase_q, lo_phase_d;
  logic               ack_drive_q, ack_drive_d;
  logic               hold_wait_q, hold_wait_d;
  logic               nack_q, nack_d;
  logic               is_addr_q, is_addr_d;
  logic               read_q, read_d;

  function automatic logic mode_valid(input logic [3:0] m);
    return (m == `ISR_MODE_7BIT) || (m == `ISR_MODE_10BIT) ||
           (m == `ISR_MODE_7BIT_SP) || (m == `ISR_MODE_10BIT_SP);
  endfunction

  function automatic logic mode_ten(input logic [3:0] m);
    return (m == `ISR_MODE_10BIT) || (m == `ISR_MODE_10BIT_SP);
  endfunction

  function automatic logic mode_sp(input logic [3:0] m);
    return (m == `ISR_MODE_7BIT_SP) || (m == `ISR_MODE_10BIT_SP);
  endfunction

  // Masked compare over the selected bit positions
  function automatic logic masked_eq(input logic [7:0] a,
                                     input logic [7:0] b,
                                     input logic [7:0] mask,
                                     input logic [7:0] sel);
    return (((a ^ b) & mask & sel) == 8'h00);
  endfunction

  // Reset release through two flops
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  isr_sync #(
    .N (`ISR_SYNC_WIDTH)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (rst_n_q),
    .din   ({SDA_I, SCL_I}),
    .lvl   (line_lvl),
    .rise  (line_rise),
    .fall  (line_fall)
  );

  assign scl_lvl   = line_lvl[`ISR_SYNC_SCL];
  assign sda_lvl   = line_lvl[`ISR_SYNC_SDA];
  assign scl_rise  = line_rise[`ISR_SYNC_SCL];
  assign scl_fall  = line_fall[`ISR_SYNC_SCL];
  assign start_det = scl_lvl & line_fall[`ISR_SYNC_SDA];
  assign stop_det  = scl_lvl & line_rise[`ISR_SYNC_SDA];

  always_comb
  begin
    logic       ten;
    logic       sp_irq;
    logic       match;
    logic       lo_miss;
    logic       rwbit;
    logic       hold;
    logic       blocked;
    logic [7:0] hi_pat;
    ten     = mode_ten(CTRL.port_mode_select);
    sp_irq  = mode_sp(CTRL.port_mode_select);
    match   = 1'b0;
    lo_miss = 1'b0;
    rwbit   = 1'b0;
    hold    = 1'b0;
    blocked = ov_q | (bf_q & ~CTRL.buffer_overwrite_enable);
    hi_pat  = {`ISR_TEN_HI_PREFIX,
               addr_q[`ISR_ADDR_HI_MSB:`ISR_ADDR_HI_LSB], 1'b0};

    state_d     = state_q;
    cnt_d       = cnt_q;
    shift_d     = shift_q;
    buf_d       = buf_q;
    addr_d      = addr_q;
    bf_d        = bf_q;
    ov_d        = ov_q;
    if_d        = if_q;
    ackt_d      = ackt_q;
    ack_received_status_d   = ack_received_status_q;
    ua_d        = ua_q;
    ua_hold_d   = ua_hold_q;
    start_d     = start_q;
    stop_d      = stop_q;
    rw_d        = rw_q;
    da_d        = da_q;
    ckp_d       = ckp_q;
    fully_d     = fully_q;
    lo_phase_d  = lo_phase_q;
    ack_drive_d = ack_drive_q;
    hold_wait_d = hold_wait_q;
    nack_d      = nack_q;
    is_addr_d   = is_addr_q;
    read_d      = read_q;

    // Software actions first so hardware sets win
    if (IRQ_FLAG_CLR)
      if_d = 1'b0;
    if (BUF_READ)
      bf_d = 1'b0;
    if (OVERFLOW_CLR)
      ov_d = 1'b0;
    if (CLOCK_RELEASE_SET)
      ckp_d = 1'b1;
    if (SLAVE_ADDR_WE)
    begin
      addr_d    = SLAVE_ADDR_WDATA;
      ua_d      = 1'b0;
      ua_hold_d = 1'b0;
    end

    if (start_det)
    begin
      // Restart behaves exactly like start
      start_d     = 1'b1;
      stop_d      = 1'b0;
      state_d     = isr_pkg::ST_ADDR;
      cnt_d       = 4'h0;
      lo_phase_d  = 1'b0;
      ack_drive_d = 1'b0;
      hold_wait_d = 1'b0;
      ackt_d      = 1'b0;
      ckp_d       = 1'b1;
      if (sp_irq || CTRL.start_irq_enable)
        if_d = 1'b1;
    end
    else if (stop_det)
    begin
      stop_d      = 1'b1;
      start_d     = 1'b0;
      state_d     = isr_pkg::ST_IDLE;
      fully_d     = 1'b0;
      lo_phase_d  = 1'b0;
      ack_drive_d = 1'b0;
      hold_wait_d = 1'b0;
      ackt_d      = 1'b0;
      ckp_d       = 1'b1;
      if (sp_irq || CTRL.stop_irq_enable)
        if_d = 1'b1;
    end
    else
    begin
      case (state_q)
        isr_pkg::ST_ADDR, isr_pkg::ST_DATA:
        begin
          if (scl_rise && cnt_q < `ISR_BITS_PER_BYTE)
          begin
            shift_d = {shift_q[6:0], sda_lvl};
            cnt_d   = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == `ISR_BITS_PER_BYTE)
          begin
            if (state_q == isr_pkg::ST_ADDR)
            begin
              rwbit = shift_q[0];
              if (!ten)
                match = masked_eq(shift_q, addr_q, CTRL.address_mask,
                                  8'hFE);
              else if (!lo_phase_q)
                match = masked_eq(shift_q, hi_pat, CTRL.address_mask,
                                  8'hFE) & (~rwbit | fully_q);
              else
              begin
                match   = masked_eq(shift_q, addr_q, CTRL.address_mask,
                                    8'hFF);
                lo_miss = ~match;
                rwbit   = 1'b0;
              end
              hold = CTRL.address_hold_enable;
            end
            else
            begin
              match = 1'b1;
              hold  = CTRL.data_hold_enable;
            end
            if (!match && !lo_miss)
              state_d = isr_pkg::ST_IDLE;
            else
            begin
              state_d   = isr_pkg::ST_ACK;
              is_addr_d = (state_q == isr_pkg::ST_ADDR);
              read_d    = (state_q == isr_pkg::ST_ADDR) & rwbit;
              if (state_q == isr_pkg::ST_ADDR)
              begin
                rw_d = rwbit;
                da_d = 1'b0;
              end
              else
                da_d = 1'b1;
              nack_d = lo_miss | blocked;
              if (blocked && bf_q)
                ov_d = 1'b1;
              if (!blocked && !lo_miss)
              begin
                buf_d = shift_q;
                bf_d  = 1'b1;
              end
              ackt_d = hold & ~lo_miss;
              if (hold && !lo_miss)
              begin
                ckp_d       = 1'b0;
                if_d        = 1'b1;
                hold_wait_d = 1'b1;
                ack_drive_d = 1'b0;
              end
              else
                ack_drive_d = ~(lo_miss | blocked);
            end
          end
        end
        isr_pkg::ST_ACK:
        begin
          if (hold_wait_q)
          begin
            if (ckp_q)
            begin
              hold_wait_d = 1'b0;
              nack_d      = CTRL.ack_data_value;
              ack_drive_d = ~CTRL.ack_data_value;
            end
          end
          else if (scl_rise)
            ack_received_status_d = sda_lvl;
          else if (scl_fall)
          begin
            ack_drive_d = 1'b0;
            ackt_d      = 1'b0;
            cnt_d       = 4'h0;
            if (is_addr_q && lo_phase_q)
            begin
              if_d       = 1'b1;
              ua_d       = 1'b1;
              ua_hold_d  = 1'b1;
              lo_phase_d = 1'b0;
              fully_d    = ~nack_q;
              state_d    = nack_q ? isr_pkg::ST_IDLE : isr_pkg::ST_DATA;
              if (!nack_q && CTRL.clock_stretch_enable)
                ckp_d = 1'b0;
            end
            else if (nack_q)
              state_d = isr_pkg::ST_IDLE;
            else
            begin
              if_d = 1'b1;
              if (read_q)
              begin
                ckp_d   = 1'b0;
                state_d = isr_pkg::ST_READ;
              end
              else if (ten && is_addr_q)
              begin
                ua_d       = 1'b1;
                ua_hold_d  = 1'b1;
                lo_phase_d = 1'b1;
                state_d    = isr_pkg::ST_ADDR;
              end
              else
              begin
                state_d = isr_pkg::ST_DATA;
                if (CTRL.clock_stretch_enable)
                  ckp_d = 1'b0;
              end
            end
          end
        end
        isr_pkg::ST_READ:
        begin
          // Transmit side sits elsewhere; stay until start or stop
        end
        isr_pkg::ST_IDLE:
        begin
        end
        default:
          state_d = isr_pkg::ST_IDLE;
      endcase
    end

    if (!mode_valid(CTRL.port_mode_select))
    begin
      state_d     = isr_pkg::ST_IDLE;
      ack_drive_d = 1'b0;
      hold_wait_d = 1'b0;
      ua_hold_d   = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q     <= isr_pkg::ST_IDLE;
      cnt_q       <= 4'h0;
      shift_q     <= `ISR_BUF_RESET;
      buf_q       <= `ISR_BUF_RESET;
      addr_q      <= `ISR_ADDR_RESET;
      bf_q        <= 1'b0;
      ov_q        <= 1'b0;
      if_q        <= 1'b0;
      ackt_q      <= 1'b0;
      ack_received_status_q   <= 1'b0;
      ua_q        <= 1'b0;
      ua_hold_q   <= 1'b0;
      start_q     <= 1'b0;
      stop_q      <= 1'b0;
      rw_q        <= 1'b0;
      da_q        <= 1'b0;
      ckp_q       <= 1'b1;
      fully_q     <= 1'b0;
      lo_phase_q  <= 1'b0;
      ack_drive_q <= 1'b0;
      hold_wait_q <= 1'b0;
      nack_q      <= 1'b0;
      is_addr_q   <= 1'b0;
      read_q      <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      shift_q     <= shift_d;
      buf_q       <= buf_d;
      addr_q      <= addr_d;
      bf_q        <= bf_d;
      ov_q        <= ov_d;
      if_q        <= if_d;
      ackt_q      <= ackt_d;
      ack_received_status_q   <= ack_received_status_d;
      ua_q        <= ua_d;
      ua_hold_q   <= ua_hold_d;
      start_q     <= start_d;
      stop_q      <= stop_d;
      rw_q        <= rw_d;
      da_q        <= da_d;
      ckp_q       <= ckp_d;
      fully_q     <= fully_d;
      lo_phase_q  <= lo_phase_d;
      ack_drive_q <= ack_drive_d;
      hold_wait_q <= hold_wait_d;
      nack_q      <= nack_d;
      is_addr_q   <= is_addr_d;
      read_q      <= read_d;
    end
  end

  // Open-drain: only ever pull low
  assign SCL_O  = 1'b0;
  assign SDA_O  = 1'b0;
  assign SCL_OE = ua_hold_q |
                  (~ckp_q & (state_q != isr_pkg::ST_IDLE));
  assign SDA_OE = ack_drive_q;

  assign STATUS.receive_buffer        = buf_q;
  assign STATUS.slave_address_reg     = addr_q;
  assign STATUS.buffer_full_flag      = bf_q;
  assign STATUS.receive_overflow_flag = ov_q;
  assign STATUS.port_interrupt_flag   = if_q;
  assign STATUS.ack_time_status       = ackt_q;
  assign STATUS.ack_received_status   = ack_received_status_q;
  assign STATUS.update_address_flag   = ua_q;
  assign STATUS.start_status          = start_q;
  assign STATUS.stop_status           = stop_q;
  assign STATUS.read_write_status     = rw_q;
  assign STATUS.data_address_status   = da_q;
  assign STATUS.clock_release_bit     = ckp_q;

endmodule

//--- design/isr_sync.sv
`timescale 1ns/10ps
module isr_sync
#(
  parameter int N = 2
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] din,
  output logic      [N-1:0] lvl,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] prev_q;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_bit
      // Bus lines idle high
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
          prev_q[g] <= 1'b1;
        end
        else
        begin
          meta_q[g] <= din[g];
          sync_q[g] <= meta_q[g];
          prev_q[g] <= sync_q[g];
        end
      end
      assign lvl[g]  = sync_q[g];
      assign rise[g] = sync_q[g] & ~prev_q[g];
      assign fall[g] = ~sync_q[g] & prev_q[g];
    end
  endgenerate

endmodule

//--- sim/isr_master_model.sv
`timescale 1ns/10ps
module isr_master_model
(
  input  wire logic dev_scl_oe,
  input  wire logic dev_sda_oe,
  output logic      scl,
  output logic      sda,
  output logic      hang
);
  logic scl_low;
  logic sda_low;

  // Wired-AND with pull-ups
  assign scl = ~(scl_low | dev_scl_oe);
  assign sda = ~(sda_low | dev_sda_oe);

  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang = 1'b0;
  end

  // Odd times keep line edges off the system clock edges
  task automatic skew();
    if ($time % 2 == 0)
      #1;
  endtask

  // Release clock, wait out any stretch
  task automatic clk_high();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 2000)
    begin
      #2;
      n++;
    end
    if (scl !== 1'b1)
      hang = 1'b1;
  endtask

  task automatic start_cond();
    skew();
    sda_low = 1'b0;
    #20;
    clk_high();
    #20;
    sda_low = 1'b1;
    #40;
    scl_low = 1'b1;
  endtask

  task automatic stop_cond();
    skew();
    sda_low = 1'b1;
    #20;
    clk_high();
    #20;
    sda_low = 1'b0;
    #40;
  endtask

  task automatic send_bits(input logic [7:0] b);
    skew();
    for (int i = 7; i >= 0; i--)
    begin
      #20;
      sda_low = ~b[i];
      #20;
      clk_high();
      #40;
      scl_low = 1'b1;
    end
  endtask

  task automatic ack_clock(output logic ack);
    skew();
    #20;
    sda_low = 1'b0;
    #20;
    clk_high();
    #20;
    ack = sda;
    #20;
    scl_low = 1'b1;
  endtask
endmodule

//--- sim/isr_sva.sv
`timescale 1ns/10ps
module isr_sva
(
  input wire logic                 MCLK,
  input wire logic                 RST_N,
  input wire logic                 SCL_I,
  input wire logic                 SCL_O,
  input wire logic                 SCL_OE,
  input wire logic                 SDA_I,
  input wire logic                 SDA_O,
  input wire logic                 SDA_OE,
  input wire isr_pkg::isr_ctrl_t   CTRL,
  input wire logic [7:0]           SLAVE_ADDR_WDATA,
  input wire logic                 SLAVE_ADDR_WE,
  input wire logic                 CLOCK_RELEASE_SET,
  input wire logic                 IRQ_FLAG_CLR,
  input wire logic                 BUF_READ,
  input wire isr_pkg::isr_status_t STATUS
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_bus_start;
    SCL_I && $past(SCL_I) && $fell(SDA_I);
  endsequence
  sequence s_bus_stop;
    SCL_I && $past(SCL_I) && $rose(SDA_I);
  endsequence

  a_start_status: assert property (
    s_bus_start |-> ##[2:6] STATUS.start_status)
    else $error("start not flagged");
  a_stop_status: assert property (
    s_bus_stop |-> ##[2:6] STATUS.stop_status)
    else $error("stop not flagged");
  a_lines_low_only: assert property (
    !(SDA_OE && SDA_O) && !(SCL_OE && SCL_O))
    else $error("line driven high");
  a_ack_clock_low: assert property (
    $rose(SDA_OE) |-> !SCL_I)
    else $error("data driven while clock high");
  a_ack_not_blocked: assert property (
    $rose(SDA_OE) && !CTRL.address_hold_enable
    && !CTRL.data_hold_enable
    |-> !$past(STATUS.receive_overflow_flag)
    && !($past(STATUS.buffer_full_flag) && !CTRL.buffer_overwrite_enable))
    else $error("ack while buffer blocked");
  a_irq_sticky: assert property (
    STATUS.port_interrupt_flag && !IRQ_FLAG_CLR
    |=> STATUS.port_interrupt_flag)
    else $error("irq flag dropped");
  a_buf_read_clr: assert property (
    BUF_READ && SCL_OE |=> !STATUS.buffer_full_flag)
    else $error("buffer full not cleared");
  a_addr_write: assert property (
    SLAVE_ADDR_WE && SCL_OE |=> !STATUS.update_address_flag
    && STATUS.slave_address_reg == $past(SLAVE_ADDR_WDATA))
    else $error("address write not taken");
  a_release_clock: assert property (
    CLOCK_RELEASE_SET && !STATUS.update_address_flag |-> ##[1:3] !SCL_OE)
    else $error("clock not released");
  a_stretch_stands: assert property (
    SCL_OE && !CLOCK_RELEASE_SET && !SLAVE_ADDR_WE
    && !$past(CLOCK_RELEASE_SET) && !$past(SLAVE_ADDR_WE) |=> SCL_OE)
    else $error("stretch ended early");
  a_ack_time_hold: assert property (
    STATUS.ack_time_status
    |-> CTRL.address_hold_enable || CTRL.data_hold_enable)
    else $error("ack time without hold");
endmodule

//--- sim/tb_top.sv
`timescale 1ns/10ps
`include "isr_cfg.svh"
module tb_top;
  localparam logic [4:0] P_WE  = 5'h10;
  localparam logic [4:0] P_REL = 5'h08;
  localparam logic [4:0] P_CLR = 5'h04;
  localparam logic [4:0] P_RD  = 5'h02;
  localparam logic [4:0] P_OVF = 5'h01;
  logic                 MCLK;
  logic                 RST_N;
  logic                 scl_oe;
  logic                 sda_oe;
  logic                 scl;
  logic                 sda;
  logic                 hang;
  logic                 ack;
  logic [7:0]           addr_wdata;
  logic [4:0]           pulses;
  logic [3:0]           modes [5];
  isr_pkg::isr_ctrl_t   ctrl;
  isr_pkg::isr_status_t st;
  int                   mismatches;
  int                   checks_done;

  always #4 MCLK = ~MCLK;

  isr_master_model u_isr_master_model (.dev_scl_oe(scl_oe),
    .dev_sda_oe(sda_oe), .scl(scl), .sda(sda), .hang(hang));
  isr_slave u_isr_slave (.MCLK(MCLK), .RST_N(RST_N), .SCL_I(scl),
    .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe),
    .CTRL(ctrl), .SLAVE_ADDR_WDATA(addr_wdata),
    .SLAVE_ADDR_WE(pulses[4]), .CLOCK_RELEASE_SET(pulses[3]),
    .IRQ_FLAG_CLR(pulses[2]), .BUF_READ(pulses[1]),
    .OVERFLOW_CLR(pulses[0]), .STATUS(st));

  task automatic report_and_stop();
    if (hang)
      mismatches++;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic sw(input logic [4:0] p);
    @(negedge MCLK);
    pulses = p;
    @(negedge MCLK);
    pulses = 5'h00;
  endtask

  task automatic settle();
    repeat (8) @(negedge MCLK);
    if (hang)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic xfer(input logic [7:0] b, input logic exp_ack);
    u_isr_master_model.send_bits(b);
    u_isr_master_model.ack_clock(ack);
    cmp(8'(ack), 8'(exp_ack));
    settle();
  endtask

  initial
  begin
    #400000;
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    MCLK = 1'b0;
    RST_N = 1'b0;
    mismatches = 0;
    checks_done = 0;
    ctrl = '0;
    ctrl.port_mode_select = `ISR_MODE_7BIT;
    ctrl.address_mask = 8'hFF;
    addr_wdata = 8'hA1;
    pulses = 5'h00;
    modes = '{`ISR_MODE_7BIT, `ISR_MODE_10BIT, `ISR_MODE_7BIT_SP,
              `ISR_MODE_10BIT_SP, `ISR_MODE_7BIT};
    repeat (4) @(negedge MCLK);
    RST_N = 1'b1;
    repeat (6) @(negedge MCLK);
    cmp(8'(st.clock_release_bit), 8'h01);
    sw(P_WE);
    cmp(st.slave_address_reg, 8'hA1);
    for (int m = 0; m < 5; m++)
    begin
      ctrl.port_mode_select = modes[m];
      ctrl.start_irq_enable = (m == 4);
      ctrl.stop_irq_enable  = (m == 4);
      u_isr_master_model.start_cond();
      settle();
      cmp(8'(st.port_interrupt_flag), 8'(modes[m][3] | (m == 4)));
      cmp(8'(st.start_status), 8'h01);
      sw(P_CLR);
      u_isr_master_model.stop_cond();
      settle();
      cmp(8'(st.stop_status), 8'h01);
      cmp(8'(st.port_interrupt_flag), 8'(modes[m][3] | (m == 4)));
      sw(P_CLR);
    end
    $display("test modes done");
    ctrl.port_mode_select = `ISR_MODE_7BIT;
    ctrl.start_irq_enable = 1'b0;
    ctrl.stop_irq_enable = 1'b0;
    u_isr_master_model.start_cond();
    xfer(8'hB0, 1'b1);
    cmp(8'(st.port_interrupt_flag), 8'h00);
    u_isr_master_model.start_cond();
    xfer(8'hA0, 1'b0);
    cmp(st.receive_buffer, 8'hA0);
    cmp(8'({st.buffer_full_flag, st.port_interrupt_flag,
            st.read_write_status}), 8'h06);
    sw(P_RD);
    cmp(8'(st.buffer_full_flag), 8'h00);
    xfer(8'h3C, 1'b0);
    cmp(8'({st.receive_buffer, st.data_address_status}), 8'h79);
    xfer(8'h5A, 1'b1);
    cmp(8'({st.receive_overflow_flag, st.ack_received_status}), 8'h03);
    u_isr_master_model.stop_cond();
    $display("test reception done");
    sw(P_RD | P_OVF | P_CLR);
    ctrl.address_mask = 8'hEF;
    u_isr_master_model.start_cond();
    xfer(8'hB0, 1'b0);
    ctrl.buffer_overwrite_enable = 1'b1;
    xfer(8'h11, 1'b0);
    cmp(st.receive_buffer, 8'h11);
    u_isr_master_model.stop_cond();
    $display("test mask done");
    sw(P_RD | P_OVF | P_CLR);
    ctrl.address_mask = 8'hFF;
    ctrl.buffer_overwrite_enable = 1'b0;
    ctrl.clock_stretch_enable = 1'b1;
    u_isr_master_model.start_cond();
    xfer(8'hA0, 1'b0);
    cmp(8'({scl_oe, st.clock_release_bit}), 8'h02);
    sw(P_RD);
    cmp(8'(st.buffer_full_flag), 8'h00);
    sw(P_REL);
    cmp(8'(scl_oe), 8'h00);
    xfer(8'h77, 1'b0);
    cmp(8'(scl_oe), 8'h01);
    sw(P_REL | P_RD);
    u_isr_master_model.stop_cond();
    settle();
    ctrl.clock_stretch_enable = 1'b0;
    $display("test stretch done");
    ctrl.address_hold_enable = 1'b1;
    ctrl.data_hold_enable = 1'b1;
    for (int v = 1; v >= 0; v--)
    begin
      sw(P_RD | P_CLR);
      ctrl.ack_data_value = v[0];
      u_isr_master_model.start_cond();
      u_isr_master_model.send_bits(8'hA0);
      settle();
      cmp(8'({st.ack_time_status, scl_oe, st.clock_release_bit}), 8'h06);
      sw(P_REL | P_RD);
      u_isr_master_model.ack_clock(ack);
      cmp(8'(ack), 8'(v[0]));
      settle();
      cmp(8'(st.ack_time_status), 8'h00);
    end
    u_isr_master_model.send_bits(8'h55);
    settle();
    cmp(8'({st.ack_time_status, scl_oe, st.data_address_status}),
        8'h07);
    sw(P_REL | P_RD);
    u_isr_master_model.ack_clock(ack);
    cmp(8'(ack), 8'h00);
    settle();
    u_isr_master_model.stop_cond();
    settle();
    ctrl.address_hold_enable = 1'b0;
    ctrl.data_hold_enable = 1'b0;
    $display("test hold done");
    ctrl.port_mode_select = `ISR_MODE_10BIT;
    addr_wdata = 8'h06;
    sw(P_WE);
    for (int k = 0; k < 2; k++)
    begin
      sw(P_RD | P_CLR);
      u_isr_master_model.start_cond();
      xfer(8'hF6, 1'b0);
      cmp(8'({st.update_address_flag, scl_oe}), 8'h03);
      addr_wdata = 8'h35;
      sw(P_WE | P_RD);
      cmp(8'(st.update_address_flag), 8'h00);
      xfer((k == 0) ? 8'h35 : 8'h34, k[0]);
      cmp(8'({st.update_address_flag, st.port_interrupt_flag, scl_oe}), 8'h07);
      addr_wdata = 8'h06;
      sw(P_WE | P_RD);
      if (k == 0)
      begin
        u_isr_master_model.start_cond();
        xfer(8'hF7, 1'b0);
        cmp(8'({st.read_write_status, scl_oe}), 8'h03);
        sw(P_REL | P_RD);
      end
      u_isr_master_model.stop_cond();
    end
    sw(P_RD | P_CLR);
    u_isr_master_model.start_cond();
    xfer(8'hF7, 1'b1);
    u_isr_master_model.stop_cond();
    $display("test ten bit done");
    report_and_stop();
  end
endmodule

bind isr_slave isr_sva u_isr_sva (.MCLK(MCLK), .RST_N(RST_N),
  .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE), .CTRL(CTRL),
  .SLAVE_ADDR_WDATA(SLAVE_ADDR_WDATA), .SLAVE_ADDR_WE(SLAVE_ADDR_WE),
  .CLOCK_RELEASE_SET(CLOCK_RELEASE_SET), .IRQ_FLAG_CLR(IRQ_FLAG_CLR),
  .BUF_READ(BUF_READ), .STATUS(STATUS));
